// File: hdl/lspm_pkg.sv
// Shared constants and types for the LED setpoint PWM and mode control block
package lspm_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SECOND_NS = 1000000000;
  localparam int unsigned CYC_PER_SEC = SECOND_NS / CLK_PERIOD_NS;
  localparam int unsigned SEC_PER_HOUR = 3600;
  localparam int unsigned HOURS_PER_SAVE = 4;
  localparam int unsigned PWM_F_MIN_HZ = 1000;
  localparam int unsigned PWM_F_MAX_HZ = 30000;
  // Longest period rounds down, shortest rounds up
  localparam int unsigned PERIOD_MAX_CYC = CYC_PER_SEC / PWM_F_MIN_HZ;
  localparam int unsigned PERIOD_MIN_CYC = (CYC_PER_SEC + PWM_F_MAX_HZ - 1) / PWM_F_MAX_HZ;
  localparam int unsigned PERIOD_W = $clog2(PERIOD_MAX_CYC + 1);
  localparam logic [2:0] SETTLE_CYC = 3'h7;
  // ****************************************
  // Non-volatile memory block map
  // ****************************************
  localparam int unsigned NVM_AW = 5;
  localparam logic [4:0] BLK_PERIOD = 5'h00;
  localparam logic [4:0] BLK_DUTY = 5'h01;
  localparam logic [4:0] BLK_HOURS = 5'h02;
  localparam logic [4:0] BLK_ONOFF = 5'h03;
  localparam logic [4:0] BLK_REF0 = 5'h04;
  localparam int unsigned NREF = 4;
  localparam logic [2:0] LOAD_LAST = 3'h7;
  localparam int unsigned SEG_SHIFT = 12;
  // ****************************************
  // Mode states
  // ****************************************
  typedef enum logic [6:0] {
    ST_START = 7'h01,
    ST_CONFIG = 7'h02,
    ST_LOAD = 7'h04,
    ST_COUNT = 7'h08,
    ST_RUN = 7'h10,
    ST_SAVE = 7'h20,
    ST_UVSAVE = 7'h40
  } lspm_state_t;
endpackage : lspm_pkg

// File: hdl/lspm_pwm_gen.sv
// Setpoint pulse generator with period-boundary reload
`timescale 1ns/1ps
module lspm_pwm_gen #(
  parameter int unsigned W = lspm_pkg::PERIOD_W
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic [W-1:0] period,
  input wire logic [W-1:0] duty,
  output logic pwm
);
  typedef struct packed {
    logic run;
    logic [W-1:0] cnt;
    logic [W-1:0] per;
    logic [W-1:0] duty;
    logic out;
  } lspm_pwm_s_t;

  lspm_pwm_s_t q;
  lspm_pwm_s_t nxt_q;

  always_comb begin
    nxt_q = q;
    nxt_q.run = enable;
    // Period counted in whole clock cycles
    // New values taken at period end, no restart
    if (!q.run || q.cnt >= q.per - W'(1) || q.per == '0) begin
      nxt_q.cnt = '0;
      nxt_q.per = period;
      nxt_q.duty = duty;
    end else begin
      nxt_q.cnt = q.cnt + W'(1);
    end
    // Duty zero stays low, duty at period stays high
    // One clock cycle of duty granularity
    nxt_q.out = enable && (nxt_q.cnt < nxt_q.duty);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= nxt_q;
    end
  end

  assign pwm = q.out;

  // ****************************************
  // Checks
  // ****************************************
  chk_duty_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    q.run && enable && q.duty == '0 && duty == '0 |=> !pwm) else $error("pwm high at zero duty");
  chk_duty_full: assert property (@(posedge core_clk) disable iff (!rst_n)
    q.run && enable && q.per != '0 && q.duty >= q.per && duty >= period && q.per == period
    |=> pwm) else $error("pwm low at full duty");
endmodule : lspm_pwm_gen

// File: hdl/led_setpoint_pwm_mode_control.sv
// Start-up, mode control, hour and on/off counting and aging interpolation
`timescale 1ns/1ps
module led_setpoint_pwm_mode_control #(
  parameter int unsigned CYC_PER_SEC = lspm_pkg::CYC_PER_SEC,
  parameter bit AGING_EN = 1'b1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic extSupplyPin,
  input wire logic readerFieldPin,
  input wire logic underVoltagePin,
  input wire logic rdrReq,
  input wire logic rdrWe,
  input wire logic [lspm_pkg::NVM_AW-1:0] rdrAddr,
  input wire logic [31:0] rdrWdata,
  output logic rdrAck,
  output logic [31:0] rdrRdata,
  output logic rdrRefused,
  output logic nvmReq,
  output logic nvmWe,
  output logic [lspm_pkg::NVM_AW-1:0] nvmAddr,
  output logic [31:0] nvmWdata,
  input wire logic nvmAck,
  input wire logic [31:0] nvmRdata,
  output logic configMode,
  output logic lightingMode,
  output logic clkSelLighting,
  output logic harvestEnable,
  output logic pwmOut,
  output logic pwmOe
);
  localparam int unsigned PW = lspm_pkg::PERIOD_W;
  localparam int unsigned NR = lspm_pkg::NREF;
  localparam int unsigned SS = lspm_pkg::SEG_SHIFT;

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] lvl;
    lspm_pkg::lspm_state_t st;
    logic [2:0] idx;
    logic iReq;
    logic iWe;
    logic [lspm_pkg::NVM_AW-1:0] iAddr;
    logic [31:0] iWdata;
    logic [PW-1:0] period;
    logic [PW-1:0] dutyBase;
    logic [PW-1:0] dutyOut;
    logic [31:0] hours;
    logic [31:0] onOff;
    logic [NR-1:0][15:0] refs;
    logic [31:0] preCnt;
    logic [11:0] secCnt;
    logic [1:0] quad;
    logic pend;
  } lspm_state_s_t;
  lspm_state_s_t q;
  lspm_state_s_t nxt_q;
  // ****************************************
  // Aging interpolation
  // ****************************************
  logic [31:0] seg;
  logic [$clog2(NR)-1:0] segIdx;
  logic signed [16:0] slope;
  logic signed [17+SS:0] prod;
  logic [15:0] factor;
  logic [PW+15:0] scaled;
  // Points spaced 2^SS hours apart, so no divider is needed
  always_comb begin
    seg = q.hours >> SS;
    segIdx = seg[$clog2(NR)-1:0];
    slope = '0;
    prod = '0;
    if (seg >= 32'(NR - 1)) begin
      factor = q.refs[NR-1];
    end else begin
      slope = $signed({1'b0, q.refs[segIdx + 1'b1]}) - $signed({1'b0, q.refs[segIdx]});
      prod = slope * $signed({1'b0, q.hours[SS-1:0]});
      factor = q.refs[segIdx] + 16'(prod >>> SS);
    end
    scaled = q.dutyBase * factor;
  end

  // ****************************************
  // Mode control
  // ****************************************
  logic inLight;
  logic tickSec;
  logic tickHour;
  assign inLight = q.st inside {lspm_pkg::ST_LOAD, lspm_pkg::ST_COUNT, lspm_pkg::ST_RUN,
                                lspm_pkg::ST_SAVE, lspm_pkg::ST_UVSAVE};
  assign tickSec = q.preCnt == CYC_PER_SEC - 1;
  assign tickHour = tickSec && q.secCnt == 12'(lspm_pkg::SEC_PER_HOUR - 1);
  always_comb begin
    nxt_q = q;
    // Pins pass three flops; a change counts when the last two agree
    nxt_q.s1 = {underVoltagePin, readerFieldPin, extSupplyPin};
    nxt_q.s2 = q.s1;
    nxt_q.s3 = q.s2;
    for (int i = 0; i < 3; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        nxt_q.lvl[i] = q.s3[i];
      end
    end
    if (q.st inside {lspm_pkg::ST_RUN, lspm_pkg::ST_SAVE}) begin
      nxt_q.preCnt = tickSec ? '0 : q.preCnt + 32'h1;
      if (tickSec) begin
        nxt_q.secCnt = tickHour ? '0 : q.secCnt + 12'h1;
      end
      if (tickHour) begin
        nxt_q.hours = q.hours + 32'h1;
        nxt_q.quad = q.quad + 2'h1;
      end
    end
    case (q.st)
      lspm_pkg::ST_START: begin
        // Let the synchronisers settle before deciding the mode
        if (q.idx != lspm_pkg::SETTLE_CYC) begin
          nxt_q.idx = q.idx + 3'h1;
        end else begin
          nxt_q.idx = '0;
          // Configuration only with field and no supply
          if (q.lvl[0]) begin
            nxt_q.st = lspm_pkg::ST_LOAD;
          end else if (q.lvl[1]) begin
            nxt_q.st = lspm_pkg::ST_CONFIG;
          end
        end
      end
      // Left only by losing power, which resets the block
      lspm_pkg::ST_CONFIG: nxt_q.st = lspm_pkg::ST_CONFIG;
      lspm_pkg::ST_LOAD: begin
        if (!q.iReq) begin
          nxt_q.iReq = 1'b1;
          nxt_q.iWe = 1'b0;
          nxt_q.iAddr = lspm_pkg::BLK_PERIOD + 5'(q.idx);
        end else if (nvmAck) begin
          nxt_q.iReq = 1'b0;
          case (q.idx)
            3'h0: nxt_q.period = nvmRdata[PW-1:0];
            3'h1: nxt_q.dutyBase = nvmRdata[PW-1:0];
            3'h2: nxt_q.hours = nvmRdata;
            3'h3: nxt_q.onOff = nvmRdata;
            default: nxt_q.refs[q.idx[1:0]] = nvmRdata[15:0];
          endcase
          nxt_q.idx = q.idx + 3'h1;
          if (q.idx == lspm_pkg::LOAD_LAST) begin
            nxt_q.st = lspm_pkg::ST_COUNT;
          end
        end
      end
      lspm_pkg::ST_COUNT: begin
        // One more power cycle, stored at once
        if (!q.iReq) begin
          nxt_q.iReq = 1'b1;
          nxt_q.iWe = 1'b1;
          nxt_q.iAddr = lspm_pkg::BLK_ONOFF;
          nxt_q.iWdata = q.onOff + 32'h1;
        end else if (nvmAck) begin
          nxt_q.iReq = 1'b0;
          nxt_q.onOff = q.iWdata;
          nxt_q.st = lspm_pkg::ST_RUN;
        end
      end
      lspm_pkg::ST_RUN: begin
        // Undervoltage save outranks the periodic one
        if (q.lvl[2]) begin
          nxt_q.st = lspm_pkg::ST_UVSAVE;
        end else if (q.pend) begin
          nxt_q.st = lspm_pkg::ST_SAVE;
        end
      end
      lspm_pkg::ST_SAVE, lspm_pkg::ST_UVSAVE: begin
        if (!q.iReq && q.iWe) begin
          nxt_q.iReq = 1'b1;
          nxt_q.iWe = 1'b1;
          nxt_q.iAddr = lspm_pkg::BLK_HOURS;
          nxt_q.iWdata = q.hours;
        end else if (nvmAck) begin
          nxt_q.iReq = 1'b0;
          nxt_q.pend = 1'b0;
          // After the emergency save the block idles until power is gone
          nxt_q.st = (q.st == lspm_pkg::ST_SAVE) ? lspm_pkg::ST_RUN : lspm_pkg::ST_UVSAVE;
          nxt_q.iWe = (q.st == lspm_pkg::ST_SAVE);
        end
      end
      default: nxt_q.st = lspm_pkg::ST_START;
    endcase
    // Every fourth hour asks for a save; the set wins over the clear
    if (tickHour && q.quad == 2'(lspm_pkg::HOURS_PER_SAVE - 1)) begin
      nxt_q.pend = 1'b1;
    end
    nxt_q.dutyOut = AGING_EN ? scaled[PW+15:16] : q.dutyBase;
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.st <= lspm_pkg::ST_START;
    end else begin
      q <= nxt_q;
    end
  end
  // ****************************************
  // Memory port and outputs
  // ****************************************
  // Reader in configuration, internal requests otherwise
  // Reader reaches memory only in configuration
  // Setup writes arrive only on the field-powered path
  assign configMode = q.st == lspm_pkg::ST_CONFIG;
  assign lightingMode = inLight;
  assign nvmReq = configMode ? rdrReq : (q.iReq && !(q.st == lspm_pkg::ST_UVSAVE && !q.iWe));
  assign nvmWe = configMode ? rdrWe : q.iWe;
  assign nvmAddr = configMode ? rdrAddr : q.iAddr;
  assign nvmWdata = configMode ? rdrWdata : q.iWdata;
  assign rdrAck = configMode && nvmAck;
  assign rdrRdata = nvmRdata;
  assign rdrRefused = !configMode && rdrReq;
  assign clkSelLighting = inLight;
  // No harvesting once supply is seen
  assign harvestEnable = !q.lvl[0] && !inLight;
  assign pwmOe = !configMode;
  // Generator runs only after load, until power-off
  // Held low while the setup is loading
  lspm_pwm_gen #(.W(PW)) u_pwm (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .enable(q.st inside {lspm_pkg::ST_RUN, lspm_pkg::ST_SAVE, lspm_pkg::ST_UVSAVE}),
    .period(q.period),
    .duty(q.dutyOut),
    .pwm(pwmOut)
  );

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  chk_cfg_hiz: assert property (configMode |-> !pwmOe && !pwmOut)
    else $error("pulse output driven in configuration");
  chk_reader_refuse: assert property (inLight && rdrReq |-> rdrRefused && !rdrAck)
    else $error("reader request not refused");
  chk_no_harvest: assert property (q.s2[0] && q.s3[0] |=> !harvestEnable)
    else $error("harvesting with supply present");
  chk_load_low: assert property (q.st inside {lspm_pkg::ST_LOAD, lspm_pkg::ST_COUNT}
    |-> ##1 !pwmOut)
    else $error("pulse high before setup loaded");
  chk_uv_entry: assert property (q.st == lspm_pkg::ST_RUN && q.lvl[2]
    |=> q.st == lspm_pkg::ST_UVSAVE ##1 (nvmReq && nvmWe && nvmAddr == lspm_pkg::BLK_HOURS))
    else $error("undervoltage save not issued");
  chk_cfg_entry: assert property ($rose(configMode)
    |-> $past(q.lvl[1]) && !$past(q.lvl[0]))
    else $error("configuration entered with supply");
  chk_onoff_inc: assert property (q.st == lspm_pkg::ST_COUNT && nvmReq
    |-> nvmWe && nvmAddr == lspm_pkg::BLK_ONOFF && nvmWdata == q.onOff + 32'h1)
    else $error("power cycle count not incremented");
  chk_clk_mode: assert property (configMode |-> !clkSelLighting ##0 !inLight)
    else $error("wrong clock select in configuration");
  chk_save_go: assert property (q.st == lspm_pkg::ST_RUN && q.pend && !q.lvl[2]
    |=> q.st == lspm_pkg::ST_SAVE ##1 (nvmReq && nvmWdata == $past(q.hours, 1)))
    else $error("periodic hour save missed");
  chk_load_order: assert property (q.st == lspm_pkg::ST_LOAD && nvmReq
    |-> !nvmWe && nvmAddr == lspm_pkg::BLK_PERIOD + 5'(q.idx))
    else $error("setup load out of order");

  cov_config: cover property ($rose(configMode));
  cov_run: cover property ($rose(q.st == lspm_pkg::ST_RUN));
  cov_uv: cover property ($rose(q.st == lspm_pkg::ST_UVSAVE));
  cov_save: cover property ($rose(q.st == lspm_pkg::ST_SAVE));
endmodule : led_setpoint_pwm_mode_control

// File: sim/lspm_nvm_model.sv
// Memory controller and LED driver input stage facing the block
`timescale 1ns/1ps
module lspm_nvm_model (
  input wire logic core_clk,
  input wire logic nvmReq,
  input wire logic nvmWe,
  input wire logic [4:0] nvmAddr,
  input wire logic [31:0] nvmWdata,
  output logic nvmAck,
  output logic [31:0] nvmRdata,
  input wire logic pwmOut
);
  logic [31:0] mem [32];
  int wrCnt [32];
  int slow = 0;
  int waitCnt = 0;
  int hiCnt = 0;
  int perCnt = 0;
  int lastHigh = 0;
  int lastPer = 0;
  int rises = 0;
  logic pwmPrev = 1'b0;
  initial begin
    nvmAck = 1'b0;
    nvmRdata = 32'h0;
    foreach (wrCnt[i]) wrCnt[i] = 0;
  end
  // ****************************************
  // Memory answer
  // ****************************************
  // Ack after chosen delay
  always @(posedge core_clk) begin
    nvmAck <= 1'b0;
    // Stale data toggles so a late sample never matches by luck
    nvmRdata <= ~nvmRdata;
    if (nvmReq && !nvmAck) begin
      if (waitCnt < slow) begin
        waitCnt <= waitCnt + 1;
      end else begin
        waitCnt <= 0;
        nvmAck <= 1'b1;
        if (nvmWe) begin
          mem[nvmAddr] <= nvmWdata;
          wrCnt[nvmAddr] <= wrCnt[nvmAddr] + 1;
        end else begin
          nvmRdata <= mem[nvmAddr];
        end
      end
    end
  end
  // ****************************************
  // Driver input stage: period and high time
  // ****************************************
  always @(posedge core_clk) begin
    pwmPrev <= pwmOut;
    if (pwmOut && !pwmPrev) begin
      lastPer <= perCnt;
      lastHigh <= hiCnt;
      perCnt <= 1;
      hiCnt <= 1;
      rises <= rises + 1;
    end else begin
      perCnt <= perCnt + 1;
      hiCnt <= hiCnt + int'(pwmOut);
    end
  end
endmodule : lspm_nvm_model

// File: sim/led_setpoint_pwm_mode_control_tb.sv
// Self-checking bench for the setpoint pulse and mode control block
`timescale 1ns/1ps
module led_setpoint_pwm_mode_control_tb;
  localparam int PMIN = lspm_pkg::PERIOD_MIN_CYC;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic extSupplyPin = 1'b0;
  logic readerFieldPin = 1'b0;
  logic underVoltagePin = 1'b0;
  logic rdrReq = 1'b0;
  logic rdrWe = 1'b0;
  logic [4:0] rdrAddr = 5'h00;
  logic [31:0] rdrWdata = 32'h0;
  logic rdrAck, rdrRefused, nvmReq, nvmWe, nvmAck, configMode, lightingMode;
  logic clkSelLighting, harvestEnable, pwmOut, pwmOe;
  logic [31:0] rdrRdata, nvmWdata, nvmRdata, got;
  logic [4:0] nvmAddr;
  int failCount = 0;
  int checkCount = 0;
  int cycles = 0;
  int per, duty, hrs, expD, n, k;
  int r0 = 32'h4000;
  int r1 = 32'h8000;

  always #5 core_clk = ~core_clk;

  led_setpoint_pwm_mode_control #(.CYC_PER_SEC(4), .AGING_EN(1'b1)) dut (
    .core_clk, .rst_n, .extSupplyPin, .readerFieldPin, .underVoltagePin,
    .rdrReq, .rdrWe, .rdrAddr, .rdrWdata, .rdrAck, .rdrRdata, .rdrRefused,
    .nvmReq, .nvmWe, .nvmAddr, .nvmWdata, .nvmAck, .nvmRdata, .configMode,
    .lightingMode, .clkSelLighting, .harvestEnable, .pwmOut, .pwmOe);
  lspm_nvm_model mdl (.core_clk, .nvmReq, .nvmWe, .nvmAddr, .nvmWdata,
    .nvmAck, .nvmRdata, .pwmOut);
  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      failCount++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  // Ceiling covers the four-hour save plus the pulse runs
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 100000) begin
      failCount++;
      tally_and_finish();
    end
  end

  // Aging factor is linear between the first two points below 4096 h
  function automatic int expDuty(int base, int h);
    longint f;
    f = r0 + ((longint'(r1 - r0) * (h % 4096)) >>> 12);
    return int'((longint'(base) * f) >>> 16);
  endfunction : expDuty

  task automatic powerUp(input logic sup, input logic fld);
    rst_n = 1'b0;
    extSupplyPin = sup;
    readerFieldPin = fld;
    underVoltagePin = 1'b0;
    repeat (5) @(negedge core_clk);
    rst_n = 1'b1;
  endtask : powerUp

  task automatic rdrXfer(input logic we, input logic [4:0] a, input int d);
    rdrReq = 1'b1;
    rdrWe = we;
    rdrAddr = a;
    rdrWdata = d;
    got = 32'h0;
    for (int i = 0; i < 20; i++) begin
      @(posedge core_clk);
      if (rdrAck === 1'b1) begin
        got = rdrRdata;
        break;
      end
    end
    @(negedge core_clk);
    rdrReq = 1'b0;
    @(negedge core_clk);
  endtask : rdrXfer

  task automatic measure();
    int r;
    r = mdl.rises;
    n = 0;
    while (mdl.rises < r + 2 && n < 2 * per + 20) begin
      @(negedge core_clk);
      n++;
    end
    if (expD == 0 || expD >= per) begin
      check(32'(mdl.rises - r), 0);
      check(pwmOut, expD != 0);
    end else begin
      check(mdl.lastPer, per);
      check(mdl.lastHigh, expD);
    end
  endtask : measure

  task automatic lightRun();
    mdl.mem[0] = per;
    mdl.mem[1] = duty;
    mdl.mem[2] = hrs;
    mdl.mem[3] = 5;
    for (int i = 4; i < 8; i++) mdl.mem[i] = (i == 4) ? r0 : r1;
    mdl.slow = $urandom_range(3);
    expD = expDuty(duty, hrs);
    n = mdl.wrCnt[3];
    // Field present too in the zero-duty run; supply must still win
    powerUp(1'b1, duty == 0);
    k = 0;
    while (!lightingMode && k < 40) begin
      @(negedge core_clk);
      k++;
    end
    check(pwmOut, 0);
    check(pwmOe, 1);
    check(harvestEnable, 0);
    check(clkSelLighting, 1);
    check(configMode, 0);
    k = 0;
    while (mdl.wrCnt[3] == n && k < 400) begin
      @(negedge core_clk);
      k++;
    end
    check(mdl.mem[3], 6);
    repeat (3) @(negedge core_clk);
    measure();
  endtask : lightRun
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    void'($urandom(4707));
    powerUp(1'b0, 1'b1);
    n = 0;
    while (!configMode && n < 40) begin
      @(negedge core_clk);
      n++;
    end
    check(configMode, 1);
    check(pwmOe, 0);
    check(clkSelLighting, 0);
    check(harvestEnable, 1);
    per = PMIN + $urandom_range(300);
    duty = 1 + $urandom_range(per - 1);
    hrs = 2048;
    rdrXfer(1'b1, 5'h00, per);
    rdrXfer(1'b1, 5'h01, duty);
    check(mdl.mem[1], duty);
    rdrXfer(1'b0, 5'h00, 0);
    check(got, per);
    mdl.mem[9] = 32'h0;
    lightRun();
    rdrReq = 1'b1;
    rdrWe = 1'b1;
    rdrAddr = 5'h09;
    rdrWdata = 32'h5a5a;
    readerFieldPin = 1'b1;
    @(negedge core_clk);
    check(rdrRefused, 1);
    check(nvmReq, 0);
    repeat (4) @(negedge core_clk);
    rdrReq = 1'b0;
    check(mdl.mem[9], 0);
    check(lightingMode, 1);
    check(harvestEnable, 0);
    n = mdl.wrCnt[2];
    underVoltagePin = 1'b1;
    k = 0;
    while (mdl.wrCnt[2] == n && k < 30) begin
      @(negedge core_clk);
      k++;
    end
    check(32'(k <= 12), 1);
    check(mdl.mem[2], hrs);
    measure();
    per = PMIN;
    duty = 0;
    hrs = $urandom_range(4095);
    lightRun();
    per = PMIN + $urandom_range(300);
    duty = 8 * per;
    lightRun();
    duty = per / 2;
    hrs = 0;
    lightRun();
    n = mdl.wrCnt[2];
    k = 0;
    while (mdl.wrCnt[2] == n && k < 60000) begin
      @(negedge core_clk);
      k++;
    end
    check(mdl.mem[2], 4);
    check(32'(k > 45000), 1);
    tally_and_finish();
  end
endmodule : led_setpoint_pwm_mode_control_tb
